// [rtl/pms_defs.svh]
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMS_ADDR_CTRL        4'h0
`define PMS_ADDR_COARSE_LO   4'h1
`define PMS_ADDR_COARSE_HI   4'h2
`define PMS_ADDR_T1_PHASE    4'h3
`define PMS_ADDR_FINE        4'h4
`define PMS_ADDR_STATUS      4'h5
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMS_CTRL_MS_LO       0
`define PMS_CTRL_SW_MODE     2
`define PMS_CTRL_REF_SEL     3
`define PMS_STAT_LOCK        0
`define PMS_STAT_HOLDOVER    4
`define PMS_STAT_STATE_LO    8
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMS_CTRL_RST         8'h00
`define PMS_COARSE_RST       8'h00
`define PMS_T1_RST           8'h00
`define PMS_FINE_RST         8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMS_CLK_MHZ          200
`define PMS_INIT_US          625
`define PMS_INIT_CYC         (`PMS_INIT_US * `PMS_CLK_MHZ)
`define PMS_DETECT_MS        35
`define PMS_DETECT_CYC       (`PMS_DETECT_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_COARSE_STEP_NS   61
`define PMS_T1_STEP_NS       81
`define PMS_FINE_STEP_PS     477
`define PMS_COARSE_MAX       2047
`endif

// [rtl/pms_pkg.sv]
package pms_pkg;
  typedef enum logic [4:0] {
    PMS_ST_RESET    = 5'h01,
    PMS_ST_FREE_RUN = 5'h02,
    PMS_ST_NORMAL   = 5'h04,
    PMS_ST_HOLDOVER = 5'h08,
    PMS_ST_AUTO_HO  = 5'h10
  } pms_state_t;

  typedef enum logic [1:0] {
    PMS_MS_NORMAL   = 2'h0,
    PMS_MS_HOLDOVER = 2'h1,
    PMS_MS_FREE_RUN = 2'h2,
    PMS_MS_RESERVED = 2'h3
  } pms_mode_t;

  typedef enum logic [1:0] {
    PMS_RATE_8K   = 2'h0,
    PMS_RATE_1M5  = 2'h1,
    PMS_RATE_2M   = 2'h2,
    PMS_RATE_19M  = 2'h3
  } pms_rate_t;
endpackage : pms_pkg

// [rtl/pms_core.sv]
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "pms_defs.svh"
module pms_core #(
  parameter int INIT_CYC   = `PMS_INIT_CYC,
  parameter int DETECT_CYC = `PMS_DETECT_CYC,
  parameter int FREQ_W     = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  input  wire logic                 mode_select_high,
  input  wire logic                 mode_select_low,
  input  wire logic                 ref_sel_pin,
  input  wire logic                 frame_pulse_8k_high,
  input  wire logic [1:0]           acq_ok,
  input  wire logic [1:0]           acq_holdover,
  input  wire logic [1:0]           acq_rate_valid,
  input  wire logic [3:0]           acq_rate,
  input  wire logic                 core_locked,
  input  wire logic [FREQ_W-1:0]    loop_freq,
  output logic [FREQ_W-1:0]         dco_freq,
  output logic                      dco_run,
  output logic                      clk_enable,
  output logic                      port_enable,
  output logic                      lock_out,
  output logic                      holdover_out,
  output logic [10:0]               coarse_offset,
  output logic [7:0]                t1_clock_phase_offset_bits,
  output logic [7:0]                fine_offset,
  output pms_pkg::pms_rate_t        ref_rate,
  output logic                      use_stored_freq
);
  import pms_pkg::*;

  initial begin
    if (INIT_CYC < 1) begin
      $error("pms_core: INIT_CYC must be at least 1");
    end
    if (DETECT_CYC < 1) begin
      $error("pms_core: DETECT_CYC must be at least 1");
    end
    if (FREQ_W < 1) begin
      $error("pms_core: FREQ_W must be at least 1");
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] sync_in;
  logic       fp_d_r;
  // Mode pins are asynchronous too, so they take the same two stages
  assign sync_in = {mode_select_high, mode_select_low, acq_ok, acq_holdover,
                    frame_pulse_8k_high, ref_sel_pin};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  // Edge detector reads only the second stage, never the first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_d_r <= 1'b0;
    end else begin
      fp_d_r <= sync2_r[1];
    end
  end

  wire       fp_rise  = sync2_r[1] & ~fp_d_r;
  wire [1:0] ms_pin_s = sync2_r[7:6];
  wire [1:0] ok_s     = sync2_r[5:4];
  wire [1:0] acq_ho_s = sync2_r[3:2];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] coarse_lo_r;
  logic [7:0] coarse_hi_r;
  logic [7:0] t1_r;
  logic [7:0] fine_r;
  logic [1:0] ms_r;
  logic       ref_sel_r;
  pms_state_t state_r;
  pms_state_t state_nxt;

  wire sw_mode = ctrl_r[`PMS_CTRL_SW_MODE];
  wire wr_ok   = reg_wr & port_enable;
  wire wr_ctrl = wr_ok & (reg_addr == `PMS_ADDR_CTRL);
  wire wr_clo  = wr_ok & (reg_addr == `PMS_ADDR_COARSE_LO);
  wire wr_chi  = wr_ok & (reg_addr == `PMS_ADDR_COARSE_HI);
  wire wr_t1   = wr_ok & (reg_addr == `PMS_ADDR_T1_PHASE);
  wire wr_fine = wr_ok & (reg_addr == `PMS_ADDR_FINE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `PMS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coarse_lo_r <= `PMS_COARSE_RST;
    end else if (wr_clo) begin
      coarse_lo_r <= reg_wdata;
    end
  end

  // Only three high bits exist, so the upper five read back as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coarse_hi_r <= `PMS_COARSE_RST;
    end else if (wr_chi) begin
      coarse_hi_r <= {5'h00, reg_wdata[2:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t1_r <= `PMS_T1_RST;
    end else if (wr_t1) begin
      t1_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fine_r <= `PMS_FINE_RST;
    end else if (wr_fine) begin
      fine_r <= reg_wdata;
    end
  end

  // Mode select and reference select captured only on the frame pulse edge
  wire [1:0] ms_src  = sw_mode ? ctrl_r[`PMS_CTRL_MS_LO +: 2] :
                                 ms_pin_s;
  wire       sel_src = sw_mode ? ctrl_r[`PMS_CTRL_REF_SEL] : sync2_r[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_r      <= 2'h2;
      ref_sel_r <= 1'b0;
    end else if (fp_rise) begin
      ms_r      <= ms_src;
      ref_sel_r <= sel_src;
    end
  end

  // ----------------------------------------
  // Reference monitoring
  // ----------------------------------------
  // Both loops stay watched so a swap to the other input is quick
  wire       act_ok    = ok_s[ref_sel_r];
  wire       act_acqho = acq_ho_s[ref_sel_r];
  wire       any_ok    = |ok_s;
  function automatic logic [1:0] pick_pair(input logic sel, input logic [3:0] pair);
    return sel ? pair[3:2] : pair[1:0];
  endfunction : pick_pair

  wire [1:0] act_rate  = pick_pair(ref_sel_r, acq_rate);
  wire       act_rvld  = ref_sel_r ? acq_rate_valid[1] : acq_rate_valid[0];
  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic       rate_known_r;
  logic [31:0] detect_cnt_r;
  logic        sel_d_r;

  // Rate change or reselection looks like a failure until re-detected
  wire rate_changed = act_rvld & rate_known_r & (act_rate != rate_r);
  wire ref_fail     = ~act_ok | rate_changed | (sel_d_r != ref_sel_r);
  wire detect_tout  = (detect_cnt_r >= 32'(DETECT_CYC - 1));
  wire ref_good     = act_ok & (act_rvld | detect_tout) & ~rate_changed;
  assign rate_nxt   = act_rvld ? act_rate : rate_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_r       <= 2'h0;
      rate_known_r <= 1'b0;
      detect_cnt_r <= 32'h0;
      sel_d_r      <= 1'b0;
    end else begin
      sel_d_r      <= ref_sel_r;
      rate_r       <= rate_nxt;
      rate_known_r <= act_rvld & act_ok;
      if (!act_ok || act_rvld) begin
        detect_cnt_r <= 32'h0;
      end else if (!detect_tout) begin
        detect_cnt_r <= detect_cnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Initialisation timer
  // ----------------------------------------
  logic [31:0] init_cnt_r;
  wire         init_done = (init_cnt_r >= 32'(INIT_CYC - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_r <= 32'h0;
    end else if (state_r == PMS_ST_RESET && !init_done) begin
      init_cnt_r <= init_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------
  // Control state machine
  // ----------------------------------------
  wire ref_is_8k = (rate_r == PMS_RATE_8K);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PMS_ST_RESET: begin
        if (init_done) state_nxt = PMS_ST_FREE_RUN;
      end
      PMS_ST_FREE_RUN: begin
        if (ms_r == PMS_MS_NORMAL && any_ok && ref_good) begin
          state_nxt = PMS_ST_NORMAL;
        end
      end
      PMS_ST_NORMAL: begin
        if (ms_r == PMS_MS_FREE_RUN) state_nxt = PMS_ST_FREE_RUN;
        else if (ms_r == PMS_MS_HOLDOVER) state_nxt = PMS_ST_HOLDOVER;
        else if (ref_fail || act_acqho) state_nxt = PMS_ST_AUTO_HO;
      end
      PMS_ST_HOLDOVER: begin
        if (ms_r == PMS_MS_FREE_RUN) state_nxt = PMS_ST_FREE_RUN;
        else if (ms_r == PMS_MS_NORMAL && ref_good && !act_acqho) begin
          state_nxt = PMS_ST_NORMAL;
        end
      end
      PMS_ST_AUTO_HO: begin
        if (ms_r == PMS_MS_FREE_RUN) state_nxt = PMS_ST_FREE_RUN;
        else if (ms_r == PMS_MS_HOLDOVER) state_nxt = PMS_ST_HOLDOVER;
        else if (ref_good && !act_acqho) begin
          // An 8 kHz reference is walked through holdover before relock
          state_nxt = ref_is_8k ? PMS_ST_HOLDOVER : PMS_ST_NORMAL;
        end
      end
      default: state_nxt = PMS_ST_RESET;
    endcase
    // Reserved code holds free-run and holdover; the normal and auto holdover states treat it as normal mode
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PMS_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Frequency word hold
  // ----------------------------------------
  // Only a locked normal-mode word is kept, so holdover never tracks a bad input
  logic [FREQ_W-1:0] stored_r;
  function automatic logic holds_freq(input pms_state_t s);
    return (s == PMS_ST_HOLDOVER) || (s == PMS_ST_AUTO_HO);
  endfunction : holds_freq

  wire in_ho   = holds_freq(state_r);
  wire running = (state_r != PMS_ST_RESET);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stored_r <= '0;
      dco_freq <= '0;
    end else begin
      if (state_r == PMS_ST_NORMAL && core_locked) begin
        stored_r <= loop_freq;
      end
      if (!running) begin
        dco_freq <= '0;
      end else if (in_ho) begin
        dco_freq <= stored_r;
      end else if (state_r == PMS_ST_NORMAL) begin
        dco_freq <= loop_freq;
      end else begin
        dco_freq <= '0;
      end
    end
  end

  // ----------------------------------------
  // Outputs and status
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_out     <= 1'b0;
      holdover_out <= 1'b0;
    end else begin
      lock_out     <= (state_r == PMS_ST_NORMAL) & core_locked;
      holdover_out <= in_ho;
    end
  end

  // Coarse offset clamps to one frame; T1 and fine offsets pass through unclamped
  wire [10:0] coarse_raw  = {coarse_hi_r[2:0], coarse_lo_r};
  wire        coarse_over = (coarse_raw > 11'(`PMS_COARSE_MAX));
  wire [10:0] coarse_lim  = coarse_over ? 11'(`PMS_COARSE_MAX) : coarse_raw;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coarse_offset              <= 11'h000;
      t1_clock_phase_offset_bits <= 8'h00;
      fine_offset                <= 8'h00;
    end else begin
      coarse_offset              <= coarse_lim;
      t1_clock_phase_offset_bits <= t1_r;
      fine_offset                <= fine_r;
    end
  end

  assign dco_run         = running;
  assign clk_enable      = running;
  assign port_enable     = running;
  assign ref_rate        = pms_rate_t'(rate_r);
  assign use_stored_freq = in_ho;

  wire [7:0] status_word = {3'h0, holdover_out, 3'h0, lock_out};
  wire [7:0] rd_mux =
    (reg_addr == `PMS_ADDR_CTRL)      ? ctrl_r      :
    (reg_addr == `PMS_ADDR_COARSE_LO) ? coarse_lo_r :
    (reg_addr == `PMS_ADDR_COARSE_HI) ? coarse_hi_r :
    (reg_addr == `PMS_ADDR_T1_PHASE)  ? t1_r        :
    (reg_addr == `PMS_ADDR_FINE)      ? fine_r      :
    (reg_addr == `PMS_ADDR_STATUS)    ? status_word : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= (reg_rd && port_enable) ? rd_mux : 8'h00;
    end
  end
endmodule : pms_core

// [testbench/pms_core_checker.sv]
`timescale 1ns/10ps
module pms_core_checker #(
  parameter int INIT_CYC   = 20,
  parameter int DETECT_CYC = 50,
  parameter int FREQ_W     = 32
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [3:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic [1:0]        acq_ok,
  input wire logic              core_locked,
  input wire logic [FREQ_W-1:0] dco_freq,
  input wire logic              clk_enable,
  input wire logic              port_enable,
  input wire logic              lock_out,
  input wire logic              holdover_out,
  input wire logic [7:0]        fine_offset,
  input wire logic              use_stored_freq
);
  logic [15:0] init_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Init length, saturating so a stuck reset state cannot wrap
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) init_cnt_r <= 16'h0000;
    else if (!port_enable && init_cnt_r != 16'hFFFF) init_cnt_r <= init_cnt_r + 16'h0001;
  end
  property p_quiet; !port_enable |-> !clk_enable && !lock_out && !holdover_out; endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs active in reset");
  property p_init; $rose(port_enable) |-> init_cnt_r >= INIT_CYC && init_cnt_r <= INIT_CYC + 2;
  endproperty
  a_init: assert property (p_init)
    else $error("init length wrong");
  property p_lock; lock_out |-> $past(core_locked) && !holdover_out; endproperty
  a_lock: assert property (p_lock)
    else $error("lock without loop lock");
  property p_fail; lock_out && acq_ok == 2'b00 |-> ##[1:8] holdover_out; endproperty
  a_fail: assert property (p_fail)
    else $error("no auto holdover on loss");
  property p_nonorm; (acq_ok == 2'b00)[*8] |-> !lock_out; endproperty
  a_nonorm: assert property (p_nonorm)
    else $error("normal with all references lost");
  property p_hold; use_stored_freq[*3] |-> $stable(dco_freq); endproperty
  a_hold: assert property (p_hold)
    else $error("holdover word moved");
  property p_fine;
    (reg_wr && port_enable && reg_addr == 4'h4) ##1 !(reg_wr && reg_addr == 4'h4)[*2]
      |-> ##1 fine_offset == $past(reg_wdata, 3);
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine offset not applied");
  property p_stat;
    reg_rd && port_enable && reg_addr == 4'h5 |=> reg_rdata[4] == $past(holdover_out);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status holdover bit differs from pin");
endmodule : pms_core_checker
bind pms_core pms_core_checker #(.INIT_CYC(INIT_CYC), .DETECT_CYC(DETECT_CYC), .FREQ_W(FREQ_W))
  u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_ok(acq_ok),
  .core_locked(core_locked), .dco_freq(dco_freq), .clk_enable(clk_enable),
  .port_enable(port_enable), .lock_out(lock_out), .holdover_out(holdover_out),
  .fine_offset(fine_offset), .use_stored_freq(use_stored_freq));

// [testbench/pms_ref_model.sv]
`timescale 1ns/10ps
module pms_ref_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] ref_fail,
  input  wire logic [1:0] rate_sel,
  output logic            frame_pulse_8k_high,
  output logic [1:0]      acq_ok,
  output logic [1:0]      acq_holdover,
  output logic [1:0]      acq_rate_valid,
  output logic [3:0]      acq_rate,
  output logic            core_locked,
  output logic [31:0]     loop_freq
);
  logic [4:0] fp_cnt_r;
  logic [3:0] lk_cnt_r;
  logic [1:0] rate_q_r;
  // ----------------------------------------
  // Both loops report all the time; a failed one shows an inverted rate, never stale data
  // ----------------------------------------
  assign acq_ok         = ~ref_fail;
  assign acq_holdover   = ref_fail;
  assign acq_rate_valid = ~ref_fail;
  assign acq_rate = {ref_fail[1] ? ~rate_sel : rate_sel, ref_fail[0] ? ~rate_sel : rate_sel};
  // Frame period shortened to 32 cycles
  assign frame_pulse_8k_high = (fp_cnt_r < 5'h04);
  assign core_locked = &lk_cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_cnt_r  <= 5'h00;
      lk_cnt_r  <= 4'h0;
      rate_q_r  <= 2'h0;
      loop_freq <= 32'h0000_1000;
    end else begin
      fp_cnt_r  <= fp_cnt_r + 5'h01;
      rate_q_r  <= rate_sel;
      // Word wanders every cycle so a frozen holdover word is visible
      loop_freq <= loop_freq + 32'h0000_0003;
      if (ref_fail != 2'b00 || rate_q_r != rate_sel) lk_cnt_r <= 4'h0;
      else if (!core_locked) lk_cnt_r <= lk_cnt_r + 4'h1;
    end
  end
endmodule : pms_ref_model

// [testbench/pms_core_test.sv]
`timescale 1ns/10ps
module pms_core_test;
  import pms_pkg::*;
  logic        clk, rst_b, reg_wr, reg_rd, msh, msl, ref_sel_pin, fp, core_locked;
  logic        dco_run, clk_enable, port_enable, lock_out, holdover_out, use_sf;
  logic [3:0]  reg_addr, acq_rate;
  logic [7:0]  reg_wdata, reg_rdata, t1_bits, fine_offset, rd_val;
  logic [1:0]  ref_fail, rate_sel, acq_ok, acq_ho, acq_rv;
  logic [31:0] loop_freq, dco_freq, frz;
  logic [10:0] coarse_offset;
  pms_rate_t   ref_rate;
  int          err_count, tests_run, n;
  pms_core #(.INIT_CYC(20), .DETECT_CYC(50), .FREQ_W(32)) i_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_select_high(msh), .mode_select_low(msl), .ref_sel_pin(ref_sel_pin),
    .frame_pulse_8k_high(fp), .acq_ok(acq_ok), .acq_holdover(acq_ho),
    .acq_rate_valid(acq_rv), .acq_rate(acq_rate), .core_locked(core_locked),
    .loop_freq(loop_freq), .dco_freq(dco_freq), .dco_run(dco_run),
    .clk_enable(clk_enable), .port_enable(port_enable), .lock_out(lock_out),
    .holdover_out(holdover_out), .coarse_offset(coarse_offset),
    .t1_clock_phase_offset_bits(t1_bits), .fine_offset(fine_offset),
    .ref_rate(ref_rate), .use_stored_freq(use_sf));
  pms_ref_model i_ref (.clk(clk), .rst_b(rst_b), .ref_fail(ref_fail), .rate_sel(rate_sel),
    .frame_pulse_8k_high(fp), .acq_ok(acq_ok), .acq_holdover(acq_ho),
    .acq_rate_valid(acq_rv), .acq_rate(acq_rate), .core_locked(core_locked),
    .loop_freq(loop_freq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd
  // Waits on holdover_out when ho is set, else on lock_out
  task wt(input logic ho, input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      if ((ho ? holdover_out : lock_out) === v) break;
    end
    chk((ho ? holdover_out : lock_out) === v, "status wait ran out");
  endtask : wt
  task ms(input logic [1:0] c);
    @(posedge clk);
    {msh, msl} <= c;
  endtask : ms
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    wr(4'h4, 8'h5A);
    repeat (18) @(posedge clk);
    rst_b <= 1'b1;
    n = 0;
    while (port_enable !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 19 && n <= 23, "init length");
    rd(4'h4);
    chk(rd_val === 8'h00, "write taken in reset");
    chk(!lock_out && !holdover_out && dco_freq === 32'h0, "not free-run");
    $display("t_reset done");
  endtask : t_reset
  task t_regs;
    wr(4'h1, 8'hA5);
    wr(4'h2, 8'hFF);
    wr(4'h3, 8'h3C);
    wr(4'h4, 8'h81);
    repeat (3) @(negedge clk);
    chk(coarse_offset === 11'h7A5, "coarse offset");
    chk(t1_bits === 8'h3C, "t1 offset");
    chk(fine_offset === 8'h81, "fine offset");
    rd(4'h2);
    chk(rd_val === 8'h07, "coarse high width");
    rd(4'hF);
    chk(rd_val === 8'h00, "unmapped read");
    $display("t_regs done");
  endtask : t_regs
  task t_lock;
    ms(2'b00);
    wt(0, 1, 600);
    chk(ref_rate === PMS_RATE_19M, "rate 19M");
    rd(4'h5);
    chk(rd_val[0] === 1'b1 && rd_val[4] === 1'b0, "status lock");
    for (int r = 2; r >= 1; r--) begin
      rate_sel <= r[1:0];
      wt(1, 1, 40);
      wt(0, 1, 600);
      chk(ref_rate === pms_rate_t'(r[1:0]), "rate detect");
    end
    $display("t_lock done");
  endtask : t_lock
  task t_fail(input logic [1:0] r);
    ref_fail <= 2'b11;
    rate_sel <= r;
    wt(1, 1, 20);
    rd(4'h5);
    chk(rd_val[4] === 1'b1 && rd_val[0] === 1'b0, "status holdover");
    frz = dco_freq;
    repeat (20) @(negedge clk);
    chk(dco_freq === frz && holdover_out, "holdover word");
    ref_fail <= 2'b00;
    wt(0, 1, 600);
    chk(ref_rate === pms_rate_t'(r), "rate after recovery");
    $display("t_fail done");
  endtask : t_fail
  task t_modes;
    ms(2'b01);
    wt(1, 1, 200);
    ms(2'b11);
    repeat (100) @(negedge clk);
    chk(holdover_out === 1'b1, "reserved code moved state");
    ms(2'b10);
    wt(1, 0, 200);
    ref_fail <= 2'b11;
    ms(2'b00);
    repeat (200) @(negedge clk);
    chk(lock_out === 1'b0, "normal with no reference");
    ref_fail <= 2'b00;
    wt(0, 1, 800);
    $display("t_modes done");
  endtask : t_modes
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    test_done;
  end
  initial begin
    {reg_wr, reg_rd, msh, msl, ref_sel_pin} = 5'b00100;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    ref_fail  = 2'b00;
    rate_sel  = 2'h3;
    rst_b     = 1'b0;
    err_count = 0;
    tests_run = 0;
    t_reset;
    t_regs;
    t_lock;
    t_fail(2'h2);
    t_fail(2'h0);
    t_modes;
    test_done;
  end
endmodule : pms_core_test
